// >>> rtl/rss_top.sv
// Reset source combiner and release sequencer
`include "rss_regs.svh"
module rss_top
   import rss_pkg::*;
(
   // Clock and power-on reset
   input wire logic clk,
   input wire logic rst_b,
   // External reset pin, active low
   input wire logic reset_pin_b,
   // Supply monitors, high while supply below level
   input wire logic below_level0,
   input wire logic below_level1,
   // Slow oscillator tick, one cycle per slow period
   input wire logic slow_tick,
   // Watchdog underflow pulse
   input wire logic wdt_underflow,
   // Processor mode register 0 write port
   input wire logic pm0_wr,
   input wire logic [7:0] pm0_wdata,
   // Option byte as stored in flash
   input wire logic [7:0] opt_flash,
   // Monitor enables from voltage control (software)
   input wire logic mon0_sw_enable,
   input wire logic mon1_sw_enable,
   // Reset outputs
   output logic sys_reset_b,
   output logic pins_input_only,
   output logic fetch_vector,
   output logic cpu_clk_slow_div8,
   output logic keep_sfr_partial,
   // Decoded option byte
   output logic wdt_autostart,
   output logic code_protect_on,
   output logic mon0_reset_en,
   output logic mon1_reset_en,
   output logic csp_mode_en,
   output logic [7:0] opt_byte
);
   ////////////////////////////////////////////////////////////////////
   // Option byte
   logic [7:0] opt_q; // Latched option byte
   logic hw_capture_r; // Capture strobe at hardware reset
   logic hw_capture_nxt;

   rss_opt_latch u_opt (
      .clk(clk),
      .rst_b(rst_b),
      .capture(hw_capture_r),
      .opt_in(opt_flash),
      .opt_q(opt_q)
   );

   ////////////////////////////////////////////////////////////////////
   // Reset sources
   logic pin_low; // Pin held low
   logic sw_reset; // Software reset write
   logic mon0_hit; // Level 0 reset active
   logic mon1_hit; // Level 1 reset active
   logic any_src; // Combined source
   logic mon0_en_r; // Monitor 0 enable, frozen
   logic mon1_en_r; // Monitor 1 enable, frozen
   logic mon0_en_nxt;
   logic mon1_en_nxt;
   logic seen_hw_r; // A hardware reset has occurred
   logic seen_hw_nxt;

   // Decode sources
   always_comb begin
      pin_low = !reset_pin_b;
      sw_reset = pm0_wr && pm0_wdata[`RSS_PM0_SWRST_BIT];
      mon0_hit = below_level0 && mon0_en_r && mon0_sw_enable;
      mon1_hit = below_level1 && mon1_en_r && mon1_sw_enable;
      any_src = pin_low || wdt_underflow || sw_reset
         || mon0_hit || mon1_hit;
   end

   // Option enables sampled only at hardware reset
   always_comb begin
      hw_capture_nxt = pin_low;
      seen_hw_nxt = seen_hw_r || hw_capture_r;
      mon0_en_nxt = mon0_en_r;
      mon1_en_nxt = mon1_en_r;
      if (hw_capture_r) begin
         mon0_en_nxt = !opt_flash[`RSS_OPT_MON0_BIT];
         mon1_en_nxt = !opt_flash[`RSS_OPT_MON1_BIT];
      end
   end

   // Power-on sets monitor 0 on, monitor 1 off until the first capture loads both
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hw_capture_r <= 1'b1;
         seen_hw_r <= 1'b0;
         mon0_en_r <= 1'b1;
         mon1_en_r <= 1'b0;
      end else begin
         hw_capture_r <= hw_capture_nxt;
         seen_hw_r <= seen_hw_nxt;
         mon0_en_r <= mon0_en_nxt;
         mon1_en_r <= mon1_en_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Release sequencer
   rss_state_e state_r;
   rss_state_e state_nxt;
   logic [5:0] cnt_r; // Slow oscillator cycles since supply good
   logic [5:0] cnt_nxt;
   logic volt_src_r; // Last reset came from a monitor
   logic volt_src_nxt;
   logic partial_r; // Last reset keeps some registers
   logic partial_nxt;
   logic fetch_r; // Start fetch pulse
   logic fetch_nxt;

   // Hold, count slow cycles for voltage resets, then run
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      volt_src_nxt = volt_src_r;
      partial_nxt = partial_r;
      fetch_nxt = 1'b0;
      unique case (state_r)
         RSS_HOLD: begin
            cnt_nxt = 6'h00;
            if (mon0_hit || mon1_hit) begin
               volt_src_nxt = 1'b1;
            end
            if (!any_src) begin
               if (volt_src_r) begin
                  state_nxt = RSS_COUNT;
               end else begin
                  state_nxt = RSS_RUN;
                  fetch_nxt = 1'b1;
               end
            end
         end
         RSS_COUNT: begin
            if (any_src) begin
               state_nxt = RSS_HOLD;
               cnt_nxt = 6'h00;
            end else if (slow_tick) begin
               cnt_nxt = cnt_r + 6'h01;
               if (cnt_r + 6'h01 == `RSS_RELEASE_COUNT) begin
                  state_nxt = RSS_RUN;
                  fetch_nxt = 1'b1;
                  volt_src_nxt = 1'b0;
               end
            end
         end
         RSS_RUN: begin
            if (any_src) begin
               state_nxt = RSS_HOLD;
               volt_src_nxt = mon0_hit || mon1_hit;
               // Only pin, level 0 monitor and power-on clear everything
               partial_nxt = !pin_low && !mon0_hit;
            end
         end
         default: begin
            state_nxt = RSS_HOLD;
         end
      endcase
   end

   // Start in hold after power-on, counting like a monitor reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= RSS_HOLD;
         cnt_r <= 6'h00;
         volt_src_r <= 1'b1;
         partial_r <= 1'b0;
         fetch_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         volt_src_r <= volt_src_nxt;
         partial_r <= partial_nxt;
         fetch_r <= fetch_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Output registers
   logic out_rst_b_r;
   logic pins_in_r; // Pins held as inputs while in reset
   logic div8_r;
   logic [4:0] dec_r; // Decoded option fields
   logic [4:0] dec_nxt;

   // Decode latched option byte
   always_comb begin
      dec_nxt[0] = !opt_q[`RSS_OPT_WDT_BIT];
      dec_nxt[1] = opt_q[`RSS_OPT_CPGATE_BIT]
         && !opt_q[`RSS_OPT_CPEN_BIT];
      dec_nxt[2] = mon0_en_r;
      dec_nxt[3] = mon1_en_r;
      dec_nxt[4] = !opt_q[`RSS_OPT_CSP_BIT];
   end

   // Internal reset and clock selection; RAM has no reset here
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         out_rst_b_r <= 1'b0;
         pins_in_r <= 1'b1;
         div8_r <= 1'b1;
         dec_r <= 5'h00;
      end else begin
         out_rst_b_r <= (state_nxt == RSS_RUN);
         pins_in_r <= (state_nxt != RSS_RUN);
         div8_r <= (state_nxt != RSS_RUN) ? 1'b1 : div8_r;
         dec_r <= dec_nxt;
      end
   end

   assign sys_reset_b = out_rst_b_r;
   assign pins_input_only = pins_in_r;
   assign fetch_vector = fetch_r;
   assign cpu_clk_slow_div8 = div8_r;
   assign keep_sfr_partial = partial_r;
   assign wdt_autostart = dec_r[0];
   assign code_protect_on = dec_r[1];
   assign mon0_reset_en = dec_r[2];
   assign mon1_reset_en = dec_r[3];
   assign csp_mode_en = dec_r[4];
   assign opt_byte = opt_q;

   ////////////////////////////////////////////////////////////////////
   // Checks
   AST_PIN_RESET: assert property (@(posedge clk) disable iff (!rst_b)
      !reset_pin_b |=> !sys_reset_b)
      else $error("pin low did not reset");
   AST_WDT_RESET: assert property (@(posedge clk) disable iff (!rst_b)
      wdt_underflow |=> !sys_reset_b)
      else $error("watchdog underflow did not reset");
   AST_SW_RESET: assert property (@(posedge clk) disable iff (!rst_b)
      (pm0_wr && pm0_wdata[3]) |=> !sys_reset_b)
      else $error("software reset ignored");
   AST_PINS_IN: assert property (@(posedge clk) disable iff (!rst_b)
      !sys_reset_b |-> pins_input_only)
      else $error("pins not inputs in reset");
   AST_FETCH: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(sys_reset_b) |-> fetch_vector)
      else $error("no vector fetch at release");
   AST_DIV8: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(sys_reset_b) |-> cpu_clk_slow_div8)
      else $error("clock not slow div8 after reset");
   AST_COUNT32: assert property (@(posedge clk) disable iff (!rst_b)
      ($rose(sys_reset_b) && $past(state_r) == RSS_COUNT) |-> cnt_r == 6'h20)
      else $error("release before 32 slow cycles");
   AST_MON0: assert property (@(posedge clk) disable iff (!rst_b)
      (below_level0 && mon0_en_r && mon0_sw_enable) |=> !sys_reset_b)
      else $error("level 0 did not reset");
   AST_PROTECT: assert property (@(posedge clk) disable iff (!rst_b)
      !opt_q[2] |=> !code_protect_on)
      else $error("protect with gate clear");
   // Pins released once the device runs
   AST_PINS_RUN: assert property (@(posedge clk) disable iff (!rst_b)
      sys_reset_b |-> !pins_input_only)
      else $error("pins still inputs while running");
   // Fetch pulse lasts a single cycle
   AST_FETCH_ONE: assert property (@(posedge clk) disable iff (!rst_b)
      fetch_vector |=> !fetch_vector)
      else $error("fetch pulse too long");
   // Fetch only with reset released
   AST_FETCH_REL: assert property (@(posedge clk) disable iff (!rst_b)
      fetch_vector |-> sys_reset_b)
      else $error("fetch while in reset");
   // No fetch while held
   AST_NO_FETCH: assert property (@(posedge clk) disable iff (!rst_b)
      !sys_reset_b |-> !fetch_vector)
      else $error("fetch during reset hold");
   // Pin, watchdog, software: release one cycle after sources clear
   AST_FAST_REL: assert property (@(posedge clk) disable iff (!rst_b)
      (state_r == RSS_HOLD && !any_src && !volt_src_r) |=> sys_reset_b)
      else $error("late release after plain reset");
   // Released only in run state
   AST_RUN_ONLY: assert property (@(posedge clk) disable iff (!rst_b)
      sys_reset_b |-> state_r == RSS_RUN)
      else $error("released outside run state");
   // Any source resets on the next edge
   AST_ANY_SRC: assert property (@(posedge clk) disable iff (!rst_b)
      any_src |=> !sys_reset_b)
      else $error("reset source ignored");
   // Level 1 monitor resets when enabled
   AST_MON1: assert property (@(posedge clk) disable iff (!rst_b)
      (below_level1 && mon1_en_r && mon1_sw_enable) |=> !sys_reset_b)
      else $error("level 1 did not reset");
   // No release from count without a slow tick
   AST_NO_EARLY: assert property (@(posedge clk) disable iff (!rst_b)
      (state_r == RSS_COUNT && !slow_tick) |=> !sys_reset_b)
      else $error("release without slow tick");
   // Counter never reaches the limit while counting
   AST_CNT_RANGE: assert property (@(posedge clk) disable iff (!rst_b)
      state_r == RSS_COUNT |-> cnt_r < 6'h20)
      else $error("count overran while counting");
   // Hold clears the counter
   AST_CNT_CLR: assert property (@(posedge clk) disable iff (!rst_b)
      state_r == RSS_HOLD |=> cnt_r == 6'h00)
      else $error("count not cleared in hold");
   // Each slow tick adds one
   AST_TICK_STEP: assert property (@(posedge clk) disable iff (!rst_b)
      (state_r == RSS_COUNT && slow_tick && !any_src)
      |=> cnt_r == $past(cnt_r) + 6'h01)
      else $error("slow tick not counted");
   // Monitor hit in hold marks a voltage reset
   AST_VOLT_SET: assert property (@(posedge clk) disable iff (!rst_b)
      (state_r == RSS_HOLD && (mon0_hit || mon1_hit)) |=> volt_src_r)
      else $error("monitor reset not remembered");
   // Voltage reset goes through the count
   AST_VOLT_CNT: assert property (@(posedge clk) disable iff (!rst_b)
      (state_r == RSS_HOLD && !any_src && volt_src_r)
      |=> state_r == RSS_COUNT)
      else $error("voltage reset skipped count");
   // Slow clock selected throughout reset
   AST_DIV8_HELD: assert property (@(posedge clk) disable iff (!rst_b)
      !sys_reset_b |-> cpu_clk_slow_div8)
      else $error("clock not slow during reset");
   // Watchdog start decode
   AST_DEC_WDT: assert property (@(posedge clk) disable iff (!rst_b)
      1'b1 |=> wdt_autostart == !$past(opt_q[`RSS_OPT_WDT_BIT]))
      else $error("watchdog start decode wrong");
   // Count source protect decode
   AST_DEC_CSP: assert property (@(posedge clk) disable iff (!rst_b)
      1'b1 |=> csp_mode_en == !$past(opt_q[`RSS_OPT_CSP_BIT]))
      else $error("count protect decode wrong");
   // Gate set and enable clear turns protection on
   AST_CP_ON: assert property (@(posedge clk) disable iff (!rst_b)
      (opt_q[`RSS_OPT_CPGATE_BIT] && !opt_q[`RSS_OPT_CPEN_BIT])
      |=> code_protect_on)
      else $error("protect not enabled");
   // Enable bit set turns protection off
   AST_CP_OFF: assert property (@(posedge clk) disable iff (!rst_b)
      opt_q[`RSS_OPT_CPEN_BIT] |=> !code_protect_on)
      else $error("protect with enable bit set");
   // Monitor enables shown one cycle later
   AST_MON0_OUT: assert property (@(posedge clk) disable iff (!rst_b)
      1'b1 |=> mon0_reset_en == $past(mon0_en_r))
      else $error("monitor 0 enable output wrong");
   AST_MON1_OUT: assert property (@(posedge clk) disable iff (!rst_b)
      1'b1 |=> mon1_reset_en == $past(mon1_en_r))
      else $error("monitor 1 enable output wrong");
   // Option byte frozen outside hardware reset
   AST_OPT_FROZEN: assert property (@(posedge clk) disable iff (!rst_b)
      !hw_capture_r |=> $stable(opt_q))
      else $error("option byte changed outside reset");
   AST_EN_FROZEN: assert property (@(posedge clk) disable iff (!rst_b)
      !hw_capture_r |=> $stable(mon0_en_r) && $stable(mon1_en_r))
      else $error("monitor enables changed outside reset");
   // Pin low arms the capture
   AST_CAPTURE: assert property (@(posedge clk) disable iff (!rst_b)
      !reset_pin_b |=> hw_capture_r)
      else $error("no capture while pin low");
   // Pin reset from run clears everything
   AST_PART_PIN: assert property (@(posedge clk) disable iff (!rst_b)
      (state_r == RSS_RUN && !reset_pin_b) |=> !keep_sfr_partial)
      else $error("pin reset kept registers");
   // Watchdog reset from run keeps some registers
   AST_PART_WDT: assert property (@(posedge clk) disable iff (!rst_b)
      (state_r == RSS_RUN && wdt_underflow && reset_pin_b && !mon0_hit)
      |=> keep_sfr_partial)
      else $error("watchdog reset cleared all");
endmodule

// >>> rtl/rss_regs.svh
// Constants for the reset source sequencer
// Contract
// - Reset pin low or watchdog underflow resets
// - Software reset bit write triggers reset
// - Pin low holds pins, CPU, registers reset
// - Pin release starts fetch at reset vector
// - After reset CPU clock is slow/8
// - RAM never cleared; write-during-reset undefined
// - Supply good: count 32 slow cycles, release
// - Monitor 0 reset stays enabled after power-on; here power-on loads it from option bit 5
// - Supply below level 0 resets device
// - Option bit 5 low enables monitor 0
// - Supply below level 1 resets, some kept
// - Option bit 0 low autostarts watchdog
// - Code protect from gate and enable bits
// - Option bit 6 low enables monitor 1
// - Option bit 7 low enables count protect
// - Erased option byte reads all ones
// - Monitor 1 option is bit 6, programmer only
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH
`define RSS_OPT_ADDR 16'hffff
`define RSS_OPT_ERASED 8'hff
`define RSS_OPT_WDT_BIT 0
`define RSS_OPT_CPGATE_BIT 2
`define RSS_OPT_CPEN_BIT 3
`define RSS_OPT_MON0_BIT 5
`define RSS_OPT_MON1_BIT 6
`define RSS_OPT_CSP_BIT 7
`define RSS_PM0_SWRST_BIT 3
`define RSS_RELEASE_COUNT 6'h20
`define RSS_PIN_LOW_NS 10000
`define RSS_CLK_NS 100
`define RSS_PIN_LOW_CYC ((`RSS_PIN_LOW_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`endif

// >>> rtl/rss_pkg.sv
// Types for the reset source sequencer
package rss_pkg;
   // Sequencer states, Gray along the usual path
   typedef enum logic [1:0] {
      RSS_HOLD = 2'b00,
      RSS_COUNT = 2'b01,
      RSS_RUN = 2'b11
   } rss_state_e;
endpackage

// >>> rtl/rss_opt_latch.sv
// Option byte capture at hardware reset
`include "rss_regs.svh"
module rss_opt_latch
   import rss_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Capture control
   input wire logic capture,
   input wire logic [7:0] opt_in,
   // Latched byte
   output logic [7:0] opt_q
);
   // Next value of latched byte
   logic [7:0] opt_r;
   logic [7:0] opt_nxt;

   // Take new byte only when told
   always_comb begin
      opt_nxt = opt_r;
      if (capture) begin
         opt_nxt = opt_in;
      end
   end

   // Erased value until first capture
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         opt_r <= `RSS_OPT_ERASED;
      end else begin
         opt_r <= opt_nxt;
      end
   end

   assign opt_q = opt_r;
endmodule

// >>> verif/rss_pin_driver_model.sv
// External reset driver model that pulls the reset pin low on request
`include "rss_regs.svh"
module rss_pin_driver_model
   import rss_pkg::*;
#(
   parameter int LOW_CYC = `RSS_PIN_LOW_CYC,
   parameter int SETTLE_CYC = 20
)
(
   // Clock
   input wire logic clk,
   // Request to pulse the pin, and power-up flavour of the pulse
   input wire logic start,
   input wire logic power_up,
   // Pin driven into the device, and busy while it is held low
   output logic reset_pin_b,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt; // Cycles left with the pin low
   initial begin
      reset_pin_b = 1'b1;
      busy = 1'b0;
      cnt = 0;
   end
   // Hold the pin low for the minimum width, plus settle time at power-up
   always @(posedge clk) begin
      if (start && !busy) begin
         reset_pin_b <= 1'b0;
         busy <= 1'b1;
         cnt <= LOW_CYC + (power_up ? SETTLE_CYC : 0);
      end else if (busy && cnt > 1) begin
         cnt <= cnt - 1;
      end else if (busy) begin
         reset_pin_b <= 1'b1;
         busy <= 1'b0;
      end
   end
endmodule

// >>> verif/reset_source_sequencer_tb.sv
// Self-checking bench for the reset source sequencer
`include "rss_regs.svh"
module reset_source_sequencer_tb
   import rss_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_b, below_level0, below_level1, slow_tick, wdt_underflow;
   logic pm0_wr, mon0_sw_enable, mon1_sw_enable, start, power_up, busy;
   logic [7:0] pm0_wdata, opt_flash, opt_byte;
   logic reset_pin_b, sys_reset_b, pins_input_only, fetch_vector;
   logic cpu_clk_slow_div8, keep_sfr_partial, wdt_autostart;
   logic code_protect_on, mon0_reset_en, mon1_reset_en, csp_mode_en;
   int n_mismatch = 0;
   int samples_checked = 0;
   int cyc = 0;
   int i;
   // Device under test
   rss_top dut_u (.clk(clk), .rst_b(rst_b), .reset_pin_b(reset_pin_b),
      .below_level0(below_level0), .below_level1(below_level1),
      .slow_tick(slow_tick), .wdt_underflow(wdt_underflow),
      .pm0_wr(pm0_wr), .pm0_wdata(pm0_wdata), .opt_flash(opt_flash),
      .mon0_sw_enable(mon0_sw_enable), .mon1_sw_enable(mon1_sw_enable),
      .sys_reset_b(sys_reset_b), .pins_input_only(pins_input_only),
      .fetch_vector(fetch_vector), .cpu_clk_slow_div8(cpu_clk_slow_div8),
      .keep_sfr_partial(keep_sfr_partial), .wdt_autostart(wdt_autostart),
      .code_protect_on(code_protect_on), .mon0_reset_en(mon0_reset_en),
      .mon1_reset_en(mon1_reset_en), .csp_mode_en(csp_mode_en),
      .opt_byte(opt_byte));
   // External reset circuit on the pin
   rss_pin_driver_model pin_u (.clk(clk), .start(start),
      .power_up(power_up), .reset_pin_b(reset_pin_b), .busy(busy));
   // Clock generator
   initial clk = 1'b0;
   always #50 clk = ~clk;
   // Slow oscillator tick every fourth cycle, plus hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      slow_tick <= (cyc % 4 == 3);
      if (cyc == 6000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   // Compare one value and count it
   task automatic chk(input string name, input logic [7:0] e,
                      input logic [7:0] got);
      samples_checked++;
      if (got !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, e, got);
      end
   endtask
   // Expected decoded option outputs
   function automatic logic [7:0] dec(input logic [7:0] o);
      return {3'b000, ~o[`RSS_OPT_CSP_BIT], ~o[`RSS_OPT_MON1_BIT],
         ~o[`RSS_OPT_MON0_BIT],
         o[`RSS_OPT_CPGATE_BIT] & ~o[`RSS_OPT_CPEN_BIT], ~o[`RSS_OPT_WDT_BIT]};
   endfunction
   // Wait for release and check its timing and side effects
   task automatic wait_rel(input int lo, input int hi);
      int n;
      n = 0;
      while (sys_reset_b !== 1'b1 && n < hi) begin
         @(negedge clk);
         n++;
      end
      chk("sys_reset_b", 1, sys_reset_b);
      chk("release not early", 1, n >= lo);
      chk("fetch_vector", 1, fetch_vector);
      chk("pins_input_only", 0, pins_input_only);
      chk("cpu_clk_slow_div8", 1, cpu_clk_slow_div8);
      @(negedge clk);
      chk("fetch_vector end", 0, fetch_vector);
   endtask
   // Pin reset through the external driver with a given option byte
   task automatic pin_rst(input logic [7:0] o, input logic pu);
      @(posedge clk);
      opt_flash <= o;
      power_up <= pu;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (3) @(negedge clk);
      chk("pin sys_reset_b", 0, sys_reset_b);
      chk("pins_input_only", 1, pins_input_only);
      while (busy === 1'b1) @(negedge clk);
      chk("held sys_reset_b", 0, sys_reset_b);
      wait_rel(0, 4);
      chk("opt_byte", o, opt_byte);
      chk("decoded", dec(o), {3'b000, csp_mode_en, mon1_reset_en,
         mon0_reset_en, code_protect_on, wdt_autostart});
      chk("keep_sfr pin", 0, keep_sfr_partial);
   endtask
   // Supply monitor dip for ten cycles
   task automatic mon_hit(input bit which, input logic hit, input logic kp);
      @(posedge clk);
      if (which) below_level1 <= 1'b1;
      else below_level0 <= 1'b1;
      repeat (10) @(posedge clk);
      below_level0 <= 1'b0;
      below_level1 <= 1'b0;
      @(negedge clk);
      chk("monitor sys_reset_b", !hit, sys_reset_b);
      if (hit) begin
         wait_rel(120, 140);
         chk("keep_sfr monitor", kp, keep_sfr_partial);
      end
   endtask
   // Single-cycle pulse on watchdog or software reset
   task automatic pulse(input bit sw, input logic [7:0] d, input logic hit);
      @(posedge clk);
      if (sw) pm0_wr <= 1'b1;
      else wdt_underflow <= 1'b1;
      pm0_wdata <= d;
      @(posedge clk);
      pm0_wr <= 1'b0;
      wdt_underflow <= 1'b0;
      @(negedge clk);
      chk("pulse sys_reset_b", !hit, sys_reset_b);
      if (hit) begin
         wait_rel(0, 4);
         chk("keep_sfr pulse", 1, keep_sfr_partial);
      end
   endtask
   // Closing report
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      rst_b = 1'b0;
      {below_level0, below_level1, wdt_underflow} = 3'h0;
      {pm0_wr, start, power_up} = 3'h0;
      pm0_wdata = 8'h00;
      opt_flash = 8'hdf;
      mon0_sw_enable = 1'b1;
      mon1_sw_enable = 1'b1;
      void'($urandom(32'h0989dd8a));
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      chk("power-on sys_reset_b", 0, sys_reset_b);
      wait_rel(120, 140);
      chk("mon0_reset_en", 1, mon0_reset_en);
      pin_rst(8'hff, 1'b1);
      pin_rst(8'h00, 1'b0);
      pin_rst(8'h04, 1'b0);
      for (i = 0; i < 6; i++) pin_rst(8'($urandom), 1'b0);
      pulse(1'b0, 8'h00, 1'b1);
      pulse(1'b1, 8'($urandom) & 8'hf7, 1'b0);
      pulse(1'b1, 8'($urandom) | 8'h08, 1'b1);
      pin_rst(8'h9f, 1'b0);
      mon_hit(1'b0, 1'b1, 1'b0);
      mon_hit(1'b1, 1'b1, 1'b1);
      pin_rst(8'hff, 1'b0);
      mon_hit(1'b0, 1'b0, 1'b0);
      mon_hit(1'b1, 1'b0, 1'b0);
      report_and_stop();
   end
endmodule
